// [logic/rsr_pkg.sv]
// types shared by the rtc ready/busy control block
// assumes rsr_regs.svh is on the include path
`include "rsr_regs.svh"

package rsr_pkg;

  typedef enum logic [0:0] {
    RSR_SYNC_IDLE,
    RSR_SYNC_WAIT
  } rsr_sync_e;

  typedef struct packed {
    logic                         meta;
    logic                         sync;
    logic                         prev;
    logic [`RSR_DIV_W-1:0]        div;
  } rsr_tick_s;

  typedef struct packed {
    logic [31:0]                  sec;
    logic [`RSR_SSEC_W-1:0]       ssec;
    logic [31:0]                  sec_snap;
    logic [`RSR_SSEC_W-1:0]       ssec_snap;
    logic [31:0]                  pend_sec;
    logic [`RSR_SSEC_W-1:0]       pend_ssec;
    logic                         pend_sec_vld;
    logic                         pend_ssec_vld;
    logic [31:0]                  trim;
    logic                         en;
    logic                         tod_ie;
    logic                         ssec_ie;
    logic                         rdy;
    logic                         ready_interrupt_enable;
    logic                         tod_alm;
    logic                         ssec_alm;
    logic                         sqw_en;
    logic                         rd_en;
    logic [`RSR_RDY_CNT_W-1:0]    rdy_cnt;
    rsr_sync_e                    sync_st;
    logic [`RSR_SYNC_CNT_W-1:0]   sync_cnt;
    logic [`RSR_IRQ_W-1:0]        irq_sts;
    logic [`RSR_IRQ_W-1:0]        irq_msk;
    logic [31:0]                  prdata;
  } rsr_state_s;

endpackage : rsr_pkg

// [logic/rsr_regs.svh]
// register offsets, field positions and timing counts of the rtc ready/busy control block
// assumes byte addresses on an apb bus with 32-bit data
`ifndef RSR_REGS_SVH
`define RSR_REGS_SVH

// byte offsets
`define RSR_OFF_SEC       8'h00
`define RSR_OFF_SSEC      8'h04
`define RSR_OFF_CTRL      8'h10
`define RSR_OFF_TRIM      8'h14
`define RSR_OFF_IRQ_STS   8'h20
`define RSR_OFF_IRQ_MSK   8'h24

// control_status field positions
`define RSR_CTRL_EN        0
`define RSR_CTRL_TOD_IE    1
`define RSR_CTRL_SSEC_IE   2
`define RSR_CTRL_BUSY      3
`define RSR_CTRL_RDY       4
`define RSR_CTRL_READY_INTERRUPT_ENABLE    5
`define RSR_CTRL_TOD_ALM   6
`define RSR_CTRL_SSEC_ALM  7
`define RSR_CTRL_SQW_EN    8
`define RSR_CTRL_RD_EN     14

// interrupt status / mask bits
`define RSR_IRQ_READY      0
`define RSR_IRQ_SYNC       1
`define RSR_IRQ_W          2

// reset value of every register
`define RSR_RESET_VAL      32'h0000_0000

// timing
`define RSR_CLK_MHZ        250
`define RSR_RDY_TIME_NS    120000
`define RSR_RDY_CYCLES     ((`RSR_RDY_TIME_NS * `RSR_CLK_MHZ) / 1000)
`define RSR_RDY_CNT_W      20
`define RSR_SYNC_TICKS     2
`define RSR_SYNC_CNT_W     2
`define RSR_SUB_DIV        8
`define RSR_DIV_W          4
`define RSR_SSEC_W         12

`endif

// [logic/rsr_sync_ctrl.sv]
// rtc ready flag, write-synchronisation busy flag and interrupt enables, apb slave
// assumes i_rst_n is power-on reset; warm resets arrive as synchronous pulses
`timescale 1ns/1ps
`default_nettype none
`include "rsr_regs.svh"

module rsr_sync_ctrl #(
  parameter int unsigned RDY_CYCLES = `RSR_RDY_CYCLES
) (
  // clock and power-on reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // warm resets
  input  wire logic        i_sys_rst,
  input  wire logic        i_soft_rst,
  input  wire logic        i_peripheral_rtc_reset_request,
  // rtc time base pin
  input  wire logic        i_time_base,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // status outputs
  output logic             o_irq,
  output logic             o_rtc_en,
  output logic             o_sqw_en
);

  localparam int unsigned RDY_W = `RSR_RDY_CNT_W;

  function automatic logic rsr_hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : rsr_hit

  function automatic logic rsr_mapped(input logic [7:0] a);
    return rsr_hit(a, `RSR_OFF_SEC) || rsr_hit(a, `RSR_OFF_SSEC) ||
           rsr_hit(a, `RSR_OFF_CTRL) || rsr_hit(a, `RSR_OFF_TRIM) ||
           rsr_hit(a, `RSR_OFF_IRQ_STS) || rsr_hit(a, `RSR_OFF_IRQ_MSK);
  endfunction : rsr_mapped

  rsr_pkg::rsr_state_s s_r;
  rsr_pkg::rsr_state_s s_nxt;

  logic                  tick;
  logic                  sub_tick;
  logic                  wr;
  logic                  rd_setup;
  logic                  wr_sec;
  logic                  wr_ssec;
  logic                  wr_ctrl;
  logic                  wr_trim;
  logic                  busy;
  logic                  warm;
  logic                  rdy_clr;
  logic                  upd;
  logic                  start;
  logic                  sync_done;
  logic [`RSR_IRQ_W-1:0] ev;
  logic [31:0]           ctrl_word;
  logic [31:0]           rd_word;

  rsr_time_base #(
    .DIV (`RSR_SUB_DIV)
  ) u_time_base (
    .i_mclk      (i_mclk),
    .i_rst_n     (i_rst_n),
    .i_en        (s_r.en),
    .i_time_base (i_time_base),
    .o_tick      (tick),
    .o_sub_tick  (sub_tick)
  );

  // bus decode
  assign wr        = i_psel & i_penable & i_pwrite;
  assign rd_setup  = i_psel & ~i_penable & ~i_pwrite;
  assign wr_sec    = wr & rsr_hit(i_paddr, `RSR_OFF_SEC);
  assign wr_ssec   = wr & rsr_hit(i_paddr, `RSR_OFF_SSEC);
  assign wr_ctrl   = wr & rsr_hit(i_paddr, `RSR_OFF_CTRL);
  assign wr_trim   = wr & rsr_hit(i_paddr, `RSR_OFF_TRIM);
  assign busy      = (s_r.sync_st == rsr_pkg::RSR_SYNC_WAIT);
  assign warm      = i_sys_rst | i_soft_rst | i_peripheral_rtc_reset_request;
  assign rdy_clr   = wr_ctrl & ~i_pwdata[`RSR_CTRL_RDY];

  always_comb begin
    ctrl_word                      = `RSR_RESET_VAL;
    ctrl_word[`RSR_CTRL_EN]        = s_r.en;
    ctrl_word[`RSR_CTRL_TOD_IE]    = s_r.tod_ie;
    ctrl_word[`RSR_CTRL_SSEC_IE]   = s_r.ssec_ie;
    ctrl_word[`RSR_CTRL_BUSY]      = busy;
    ctrl_word[`RSR_CTRL_RDY]       = s_r.rdy;
    ctrl_word[`RSR_CTRL_READY_INTERRUPT_ENABLE]    = s_r.ready_interrupt_enable;
    ctrl_word[`RSR_CTRL_TOD_ALM]   = s_r.tod_alm;
    ctrl_word[`RSR_CTRL_SSEC_ALM]  = s_r.ssec_alm;
    ctrl_word[`RSR_CTRL_SQW_EN]    = s_r.sqw_en;
    ctrl_word[`RSR_CTRL_RD_EN]     = s_r.rd_en;
  end

  always_comb begin
    rd_word = `RSR_RESET_VAL;
    case (i_paddr)
      `RSR_OFF_SEC:     rd_word = s_r.rd_en ? s_r.sec : s_r.sec_snap;
      `RSR_OFF_SSEC:    rd_word[`RSR_SSEC_W-1:0] = s_r.rd_en ? s_r.ssec : s_r.ssec_snap;
      `RSR_OFF_CTRL:    rd_word = ctrl_word;
      `RSR_OFF_TRIM:    rd_word = s_r.trim;
      `RSR_OFF_IRQ_STS: rd_word[`RSR_IRQ_W-1:0] = s_r.irq_sts;
      `RSR_OFF_IRQ_MSK: rd_word[`RSR_IRQ_W-1:0] = s_r.irq_msk;
      default:          rd_word = `RSR_RESET_VAL;
    endcase
  end

  always_comb begin
    s_nxt     = s_r;
    upd       = 1'b0;
    start     = 1'b0;
    sync_done = 1'b0;
    ev        = '0;
    // synchronisation into the rtc domain, counted in time base ticks
    case (s_r.sync_st)
      rsr_pkg::RSR_SYNC_IDLE: begin
        s_nxt.sync_cnt = '0;
      end
      rsr_pkg::RSR_SYNC_WAIT: begin
        if (tick) begin
          if (s_r.sync_cnt <= `RSR_SYNC_CNT_W'(1)) begin
            s_nxt.sync_st = rsr_pkg::RSR_SYNC_IDLE;
            sync_done     = 1'b1;
          end else begin
            s_nxt.sync_cnt = s_r.sync_cnt - `RSR_SYNC_CNT_W'(1);
          end
        end
      end
      default: begin
        s_nxt.sync_st = rsr_pkg::RSR_SYNC_IDLE;
      end
    endcase
    // counters: a completed load wins over counting
    if (sync_done && (s_r.pend_sec_vld || s_r.pend_ssec_vld)) begin
      if (s_r.pend_sec_vld) begin
        s_nxt.sec = s_r.pend_sec;
      end
      if (s_r.pend_ssec_vld) begin
        s_nxt.ssec = s_r.pend_ssec;
      end
      upd = 1'b1;
    end else if (sub_tick) begin
      s_nxt.ssec = s_r.ssec + `RSR_SSEC_W'(1);
      if (&s_r.ssec) begin
        s_nxt.sec = s_r.sec + 32'h0000_0001;
      end
      upd = 1'b1;
    end
    if (sync_done) begin
      s_nxt.pend_sec_vld  = 1'b0;
      s_nxt.pend_ssec_vld = 1'b0;
    end
    if (upd) begin
      s_nxt.sec_snap  = s_nxt.sec;
      s_nxt.ssec_snap = s_nxt.ssec;
    end
    // ready window
    if (s_r.rdy) begin
      if (s_r.rdy_cnt <= RDY_W'(1)) begin
        s_nxt.rdy = 1'b0;
      end else begin
        s_nxt.rdy_cnt = s_r.rdy_cnt - RDY_W'(1);
      end
    end
    if (rdy_clr) begin
      s_nxt.rdy = 1'b0;
    end
    if (upd) begin
      s_nxt.rdy     = 1'b1;
      s_nxt.rdy_cnt = RDY_W'(RDY_CYCLES);
      ev[`RSR_IRQ_READY] = s_r.ready_interrupt_enable;
    end
    ev[`RSR_IRQ_SYNC] = sync_done;
    // register writes
    if (wr_sec) begin
      s_nxt.pend_sec     = i_pwdata;
      s_nxt.pend_sec_vld = 1'b1;
      start              = 1'b1;
    end
    if (wr_ssec) begin
      s_nxt.pend_ssec     = i_pwdata[`RSR_SSEC_W-1:0];
      s_nxt.pend_ssec_vld = 1'b1;
      start               = 1'b1;
    end
    if (wr_trim) begin
      s_nxt.trim = i_pwdata;
      start      = 1'b1;
    end
    if (wr_ctrl && !busy) begin
      s_nxt.en       = i_pwdata[`RSR_CTRL_EN];
      s_nxt.tod_ie   = i_pwdata[`RSR_CTRL_TOD_IE];
      s_nxt.ssec_ie  = i_pwdata[`RSR_CTRL_SSEC_IE];
      s_nxt.ready_interrupt_enable   = i_pwdata[`RSR_CTRL_READY_INTERRUPT_ENABLE];
      s_nxt.tod_alm  = i_pwdata[`RSR_CTRL_TOD_ALM];
      s_nxt.ssec_alm = i_pwdata[`RSR_CTRL_SSEC_ALM];
      s_nxt.sqw_en   = i_pwdata[`RSR_CTRL_SQW_EN];
      s_nxt.rd_en    = i_pwdata[`RSR_CTRL_RD_EN];
      start          = 1'b1;
    end
    if (start) begin
      s_nxt.sync_st  = rsr_pkg::RSR_SYNC_WAIT;
      s_nxt.sync_cnt = `RSR_SYNC_CNT_W'(`RSR_SYNC_TICKS);
    end
    // sticky interrupt status: a new event wins over a write-one clear
    s_nxt.irq_sts = s_r.irq_sts;
    if (wr && rsr_hit(i_paddr, `RSR_OFF_IRQ_STS)) begin
      s_nxt.irq_sts = s_r.irq_sts & ~i_pwdata[`RSR_IRQ_W-1:0];
    end
    s_nxt.irq_sts = s_nxt.irq_sts | ev;
    if (wr && rsr_hit(i_paddr, `RSR_OFF_IRQ_MSK)) begin
      s_nxt.irq_msk = i_pwdata[`RSR_IRQ_W-1:0];
    end
    // read data captured in the setup phase
    if (rd_setup) begin
      s_nxt.prdata = rd_word;
    end
    // warm resets leave busy and the power-on fields alone
    if (warm) begin
      s_nxt.rdy     = 1'b0;
      s_nxt.ready_interrupt_enable  = 1'b0;
      s_nxt.rdy_cnt = '0;
      s_nxt.irq_sts = '0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs
  assign o_prdata  = s_r.prdata;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~rsr_mapped(i_paddr);
  assign o_irq     = |(s_r.irq_sts & s_r.irq_msk);
  assign o_rtc_en  = s_r.en;
  assign o_sqw_en  = s_r.sqw_en;

  // checks
  property p_rdy_set;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (upd && !warm) |=> (s_r.rdy && s_r.rdy_cnt == RDY_W'(RDY_CYCLES));
  endproperty
  a_rdy_set: assert property (p_rdy_set) else $error("ready not set after update");

  property p_rdy_expire;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (s_r.rdy && s_r.rdy_cnt == RDY_W'(1) && !upd) |=> !s_r.rdy;
  endproperty
  a_rdy_expire: assert property (p_rdy_expire) else $error("ready outlived window");

  property p_rdy_hold;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (s_r.rdy && s_r.rdy_cnt > RDY_W'(1) && !rdy_clr && !warm) |=> s_r.rdy;
  endproperty
  a_rdy_hold: assert property (p_rdy_hold) else $error("ready dropped early");

  property p_rdy_clr;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (rdy_clr && !upd) |=> !s_r.rdy;
  endproperty
  a_rdy_clr: assert property (p_rdy_clr) else $error("software clear of ready lost");

  property p_rdy_irq;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (upd && s_r.ready_interrupt_enable && s_r.irq_msk[`RSR_IRQ_READY] && !warm && !wr) |=> ##1 o_irq;
  endproperty
  a_rdy_irq: assert property (p_rdy_irq) else $error("ready interrupt missing");

  property p_rdy_irq_cause;
    @(posedge i_mclk) disable iff (!i_rst_n)
    $rose(s_r.irq_sts[`RSR_IRQ_READY]) |-> $past(s_r.ready_interrupt_enable) && $past(upd);
  endproperty
  a_rdy_irq_cause: assert property (p_rdy_irq_cause) else $error("ready event while disabled");

  property p_ready_interrupt_enable_wr;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (wr_ctrl && !busy && !warm) |=> s_r.ready_interrupt_enable == $past(i_pwdata[`RSR_CTRL_READY_INTERRUPT_ENABLE]);
  endproperty
  a_ready_interrupt_enable_wr: assert property (p_ready_interrupt_enable_wr) else $error("ready enable write lost");

  property p_busy_start;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (wr_sec || wr_ssec || wr_trim || (wr_ctrl && !busy)) |=> busy && ctrl_word[`RSR_CTRL_BUSY];
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not raised by write");

  property p_busy_block;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (wr_ctrl && busy && !warm) |=>
      $stable(s_r.ready_interrupt_enable) && $stable(s_r.ssec_ie) && $stable(s_r.en) && $stable(s_r.rd_en);
  endproperty
  a_busy_block: assert property (p_busy_block) else $error("control written while busy");

  property p_busy_done;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (sync_done && !start) |=> !busy;
  endproperty
  a_busy_done: assert property (p_busy_done) else $error("busy stuck after sync");

  property p_ssec_ie_wr;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (wr_ctrl && !busy) |=> s_r.ssec_ie == $past(i_pwdata[`RSR_CTRL_SSEC_IE]);
  endproperty
  a_ssec_ie_wr: assert property (p_ssec_ie_wr) else $error("subsecond enable write lost");

  property p_warm_keep;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (warm && !start && !sync_done && !wr_ctrl) |=>
      busy == $past(busy) && s_r.ssec_ie == $past(s_r.ssec_ie);
  endproperty
  a_warm_keep: assert property (p_warm_keep) else $error("warm reset hit power-on field");

  property p_warm_clr;
    @(posedge i_mclk) disable iff (!i_rst_n)
    warm |=> !s_r.rdy && !s_r.ready_interrupt_enable;
  endproperty
  a_warm_clr: assert property (p_warm_clr) else $error("warm reset left ready set");

  property p_direct_read;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (rd_setup && rsr_hit(i_paddr, `RSR_OFF_SEC) && s_r.rd_en) |=> o_prdata == $past(s_r.sec);
  endproperty
  a_direct_read: assert property (p_direct_read) else $error("direct read not live");

endmodule : rsr_sync_ctrl

`default_nettype wire

// [logic/rsr_time_base.sv]
// time base front end: synchronises the 32 kHz pin and makes tick strobes
// assumes the pin is asynchronous to i_mclk and much slower than it
`timescale 1ns/1ps
`default_nettype none
`include "rsr_regs.svh"

module rsr_time_base #(
  parameter int unsigned DIV = `RSR_SUB_DIV
) (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  // control
  input  wire logic i_en,
  input  wire logic i_time_base,
  // strobes
  output logic      o_tick,
  output logic      o_sub_tick
);

  rsr_pkg::rsr_tick_s s_r;
  rsr_pkg::rsr_tick_s s_nxt;

  always_comb begin
    s_nxt      = s_r;
    o_sub_tick = 1'b0;
    s_nxt.meta = i_time_base;
    s_nxt.sync = s_r.meta;
    s_nxt.prev = s_r.sync;
    o_tick     = s_r.sync & ~s_r.prev;
    if (o_tick && i_en) begin
      if (s_r.div == `RSR_DIV_W'(DIV - 1)) begin
        s_nxt.div  = '0;
        o_sub_tick = 1'b1;
      end else begin
        s_nxt.div = s_r.div + `RSR_DIV_W'(1);
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : rsr_time_base

`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the rtc ready/busy control block over apb
// assumes rsr_sync_ctrl with zero-wait apb and a time base pin driven here
`timescale 1ns/1ps
`default_nettype none
`include "rsr_regs.svh"

module tb_top;
  localparam int unsigned RDY_N = 20;
  localparam logic [31:0] EN_B  = 32'h0000_0001 << `RSR_CTRL_EN;
  localparam logic [31:0] SS_B  = 32'h0000_0001 << `RSR_CTRL_SSEC_IE;
  localparam logic [31:0] BSY_B = 32'h0000_0001 << `RSR_CTRL_BUSY;
  localparam logic [31:0] RDY_B = 32'h0000_0001 << `RSR_CTRL_RDY;
  localparam logic [31:0] RIE_B = 32'h0000_0001 << `RSR_CTRL_READY_INTERRUPT_ENABLE;
  localparam logic [31:0] SQW_B = 32'h0000_0001 << `RSR_CTRL_SQW_EN;
  localparam logic [31:0] RDE_B = 32'h0000_0001 << `RSR_CTRL_RD_EN;
  localparam logic [31:0] CFG   = EN_B | SS_B | RIE_B;

  logic        clk, rst_n, sys_rst, soft_rst, per_rst, time_base;
  logic        psel, penable, pwrite, pready, pslverr, irq, rtc_en, sqw_en, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          num_errors, n_compared;

  rsr_sync_ctrl #(.RDY_CYCLES(RDY_N)) uut (
    .i_mclk(clk), .i_rst_n(rst_n), .i_sys_rst(sys_rst), .i_soft_rst(soft_rst),
    .i_peripheral_rtc_reset_request(per_rst), .i_time_base(time_base),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_irq(irq), .o_rtc_en(rtc_en), .o_sqw_en(sqw_en));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; leaves read data in rd and error in err
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      chk(32'h0000_0000, 32'h0000_0001);
      tally_and_finish();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdchk

  task automatic tick;
    time_base <= 1'b1;
    repeat (4) @(posedge clk);
    time_base <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : tick

  // ticks the time base until busy reads 0; rd keeps that control read
  task automatic wait_idle;
    int n;
    for (n = 0; n < 12; n++) begin
      tick();
      xfer(1'b0, `RSR_OFF_CTRL, 32'h0000_0000);
      if (rd[`RSR_CTRL_BUSY] === 1'b0) return;
    end
    chk(rd, rd & ~BSY_B);
    tally_and_finish();
  endtask : wait_idle

  task automatic s_reset_values;
    rdchk(`RSR_OFF_CTRL, 32'h0000_0000);
    rdchk(`RSR_OFF_IRQ_STS, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask : s_reset_values

  task automatic s_config;
    xfer(1'b1, `RSR_OFF_CTRL, CFG);
    rdchk(`RSR_OFF_CTRL, CFG | BSY_B);
    chk({31'h0, rtc_en}, 32'h0000_0001);
    wait_idle();
    chk(rd & ~RDY_B, CFG);
    xfer(1'b1, `RSR_OFF_IRQ_STS, 32'h0000_0003);
  endtask : s_config

  task automatic s_sec_update;
    xfer(1'b1, `RSR_OFF_SEC, 32'h0000_1234);
    rdchk(`RSR_OFF_CTRL, CFG | BSY_B);
    xfer(1'b1, `RSR_OFF_CTRL, SQW_B);
    rdchk(`RSR_OFF_CTRL, CFG | BSY_B);
    chk({31'h0, sqw_en}, 32'h0000_0000);
    wait_idle();
    chk(rd & (RDY_B | BSY_B), RDY_B);
    rdchk(`RSR_OFF_SEC, 32'h0000_1234);
    rdchk(`RSR_OFF_IRQ_STS, 32'h0000_0003);
    chk({31'h0, irq}, 32'h0000_0000);
    xfer(1'b1, `RSR_OFF_IRQ_MSK, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    xfer(1'b1, `RSR_OFF_IRQ_STS, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    repeat (RDY_N + 4) @(posedge clk);
    xfer(1'b0, `RSR_OFF_CTRL, 32'h0000_0000);
    chk(rd & RDY_B, 32'h0000_0000);
  endtask : s_sec_update

  task automatic s_clear_rdy;
    xfer(1'b1, `RSR_OFF_SSEC, 32'h0000_0042);
    wait_idle();
    chk(rd & RDY_B, RDY_B);
    xfer(1'b1, `RSR_OFF_CTRL, CFG);
    rdchk(`RSR_OFF_CTRL, CFG | BSY_B);
    wait_idle();
  endtask : s_clear_rdy

  // ready is still inside its window when the warm reset lands
  task automatic s_warm(input int k);
    xfer(1'b1, `RSR_OFF_CTRL, CFG);
    wait_idle();
    xfer(1'b1, `RSR_OFF_SSEC, 32'h0000_0010);
    wait_idle();
    chk(rd & RDY_B, RDY_B);
    xfer(1'b1, `RSR_OFF_IRQ_STS, 32'h0000_0003);
    xfer(1'b1, `RSR_OFF_TRIM, 32'h0000_0005);
    if (k == 0) sys_rst <= 1'b1;
    else if (k == 1) soft_rst <= 1'b1;
    else per_rst <= 1'b1;
    @(posedge clk);
    sys_rst  <= 1'b0;
    soft_rst <= 1'b0;
    per_rst  <= 1'b0;
    rdchk(`RSR_OFF_CTRL, EN_B | SS_B | BSY_B);
    wait_idle();
    rdchk(`RSR_OFF_IRQ_STS, 32'h0000_0002);
  endtask : s_warm

  task automatic s_unmapped;
    xfer(1'b0, 8'h08, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    xfer(1'b0, `RSR_OFF_CTRL, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0000);
  endtask : s_unmapped

  task automatic s_direct;
    xfer(1'b1, `RSR_OFF_CTRL, CFG | SQW_B | RDE_B);
    wait_idle();
    chk(rd & ~RDY_B, CFG | SQW_B | RDE_B);
    chk({31'h0, sqw_en}, 32'h0000_0001);
    rdchk(`RSR_OFF_SEC, 32'h0000_1234);
  endtask : s_direct

  task automatic s_por;
    xfer(1'b1, `RSR_OFF_SEC, 32'h0000_0001);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(`RSR_OFF_CTRL, 32'h0000_0000);
  endtask : s_por

  initial begin
    num_errors = 0;
    n_compared = 0;
    rst_n = 1'b0;
    {sys_rst, soft_rst, per_rst, time_base} = 4'h0;
    {psel, penable, pwrite} = 3'h0;
    paddr  = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    s_reset_values();
    s_config();
    s_sec_update();
    s_clear_rdy();
    for (int k = 0; k < 3; k++) s_warm(k);
    s_unmapped();
    s_direct();
    s_por();
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge clk);
    chk(32'h0000_0000, 32'h0000_0001);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
